/* File: trajectory_parameter_latch.sv */
// Trajectory parameter store, buffered latch and velocity command path of a servo drive.
//
// Behaviour
// RULE_01: Software position limits act only once homing has referenced the axis.
// RULE_02: Master disables the lower limit by writing a minimum below the negative limit.
// RULE_03: Master disables the upper limit by writing a maximum above the positive limit.
// RULE_04: Profile velocity command magnitude is clamped to maximum profile velocity, both directions.
// RULE_05: In profile velocity mode a new target velocity reaches the generator at once.
// RULE_06: Profile position parameters are buffered and applied on control-word bit 4 rising.
// RULE_07: The buffered profile velocity becomes the cruise speed in profile position mode.
// RULE_08: End velocity is the speed on arrival at the target, normally zero.
// RULE_09: End velocity is applied only with the trapezoidal generator, otherwise zero.
// RULE_10: S-curve moves use profile acceleration for both acceleration and final deceleration.
// RULE_11: Profile deceleration serves trapezoidal and special velocity profiles, ignored for S-curve.
// RULE_12: Quick stop ramps command velocity toward zero at the quick-stop rate.
// RULE_13: The quick-stop ramp applies in homing, profile position and interpolated modes.
// RULE_14: Quick-stop deceleration is unbuffered; a new value acts during a ramp immediately.
// RULE_15: A quick-stop deceleration of zero forces command velocity to zero at once.
// RULE_16: Trajectory type accepts only 0, 3 and -1; other values are rejected.
// RULE_17: Shadow copies of all buffered parameters enter the active set in one cycle.
`timescale 1ns/1ps
module trajectory_parameter_latch (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Object dictionary access
  input wire logic od_write,
  input wire logic od_read,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_subindex,
  input wire logic [31:0] od_wdata,
  output logic [31:0] od_rdata_reg,
  output logic od_ack_reg,
  output logic od_error_reg,
  // Drive state
  input wire logic [7:0] op_mode,
  input wire logic [15:0] control_word,
  input wire logic homed,
  input wire logic quick_stop,
  input wire logic [31:0] position_demand,
  input wire logic [31:0] loop_velocity,
  // Trajectory generator side
  output traj_param_pkg::applied_type applied_reg,
  output logic [31:0] velocity_target_reg,
  output logic [31:0] velocity_command,
  output logic stopped,
  // Soft limit flags
  output logic limit_low_reg,
  output logic limit_high_reg
);
  import traj_param_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] limit_min_reg;
  logic [31:0] limit_min_next;
  logic [31:0] limit_max_reg;
  logic [31:0] limit_max_next;
  logic [31:0] max_pv_reg;
  logic [31:0] max_pv_next;
  logic [31:0] max_motor_reg;
  logic [31:0] max_motor_next;
  logic [31:0] qs_decel_reg;
  logic [31:0] qs_decel_next;
  logic [31:0] target_vel_reg;
  logic [31:0] target_vel_next;
  profile_set_type shadow_reg;
  profile_set_type shadow_next;
  profile_set_type active_reg;
  profile_set_type active_next;
  applied_type applied_next;
  logic cw_prev_reg;
  logic [31:0] od_rdata_next;
  logic od_ack_next;
  logic od_error_next;
  logic [31:0] velocity_target_next;
  logic limit_low_next;
  logic limit_high_next;
  logic latch;
  logic hit;
  logic bad_value;
  logic [31:0] rd_value;
  logic ramp_enable;
  logic [31:0] ramp_source;
  logic pv_mode;

  // Clamps a signed velocity to plus or minus an unsigned magnitude.
  function automatic logic [31:0] clamp_velocity(input logic [31:0] v, input logic [31:0] lim);
    logic signed [32:0] vw;
    logic signed [32:0] lw;
    logic signed [32:0] neg;
    vw = {v[31], v};
    lw = {1'b0, lim};
    neg = -lw;
    if (vw > lw) begin
      return lim;
    end else if (vw < neg) begin
      return neg[31:0];
    end else begin
      return v;
    end
  endfunction

  // ----------------------------------------------------------------
  // Object decode and register writes
  // ----------------------------------------------------------------

  // Decodes an access, updates the stored objects and forms the read value.
  always_comb begin
    limit_min_next = limit_min_reg;
    limit_max_next = limit_max_reg;
    max_pv_next = max_pv_reg;
    max_motor_next = max_motor_reg;
    qs_decel_next = qs_decel_reg;
    target_vel_next = target_vel_reg;
    shadow_next = shadow_reg;
    hit = 1'b1;
    bad_value = 1'b0;
    rd_value = RESET_ZERO;
    unique case (od_index)
      IDX_SOFT_LIMIT: begin
        if (od_subindex == SUB_LIMIT_MIN) begin
          rd_value = limit_min_reg;
          if (od_write) begin
            limit_min_next = od_wdata;
          end
        end else if (od_subindex == SUB_LIMIT_MAX) begin
          rd_value = limit_max_reg;
          if (od_write) begin
            limit_max_next = od_wdata;
          end
        end else begin
          hit = 1'b0;
        end
      end
      IDX_MAX_PROFILE_VEL: begin
        rd_value = max_pv_reg;
        if (od_write) begin
          max_pv_next = od_wdata;
        end
      end
      IDX_MAX_MOTOR_SPEED: begin
        rd_value = max_motor_reg;
        if (od_write) begin
          max_motor_next = od_wdata;
        end
      end
      IDX_PROFILE_VEL: begin
        rd_value = shadow_reg.velocity;
        if (od_write) begin
          shadow_next.velocity = od_wdata; // RULE_06
        end
      end
      IDX_END_VEL: begin
        rd_value = shadow_reg.end_velocity;
        if (od_write) begin
          shadow_next.end_velocity = od_wdata; // RULE_06
        end
      end
      IDX_PROFILE_ACCEL: begin
        rd_value = shadow_reg.accel;
        if (od_write) begin
          shadow_next.accel = od_wdata; // RULE_06
        end
      end
      IDX_PROFILE_DECEL: begin
        rd_value = shadow_reg.decel;
        if (od_write) begin
          shadow_next.decel = od_wdata; // RULE_06
        end
      end
      IDX_QS_DECEL: begin
        rd_value = qs_decel_reg;
        if (od_write) begin
          qs_decel_next = od_wdata; // RULE_14
        end
      end
      IDX_PROFILE_TYPE: begin
        rd_value = {TYPE_PAD, shadow_reg.ptype};
        if (od_write) begin
          if ((od_wdata[15:0] == PROFILE_TRAPEZOID) || (od_wdata[15:0] == PROFILE_SCURVE) ||
              (od_wdata[15:0] == PROFILE_VELOCITY)) begin
            shadow_next.ptype = od_wdata[15:0];
          end else begin
            bad_value = 1'b1; // RULE_16
          end
        end
      end
      IDX_TARGET_VEL: begin
        rd_value = target_vel_reg;
        if (od_write) begin
          target_vel_next = od_wdata; // RULE_05
        end
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (!(od_write || od_read)) begin
      hit = 1'b0;
    end
    od_ack_next = od_write || od_read;
    od_error_next = (od_write || od_read) && (!hit || bad_value);
    od_rdata_next = (od_read && hit) ? rd_value : od_rdata_reg;
  end

  // ----------------------------------------------------------------
  // Latch, applied set and velocity target
  // ----------------------------------------------------------------

  // Copies the whole shadow set on a rising new-setpoint bit in profile position mode.
  always_comb begin
    pv_mode = (op_mode == MODE_PROFILE_VELOCITY);
    latch = (op_mode == MODE_PROFILE_POSITION) && control_word[CW_NEW_SETPOINT_BIT] && !cw_prev_reg; // RULE_06
    active_next = latch ? shadow_reg : active_reg; // RULE_17
    applied_next.cruise_velocity = active_next.velocity; // RULE_07
    applied_next.end_velocity = (active_next.ptype == PROFILE_TRAPEZOID) ?
                                active_next.end_velocity : RESET_ZERO; // RULE_08 RULE_09
    applied_next.accel = active_next.accel; // RULE_10
    applied_next.decel = (active_next.ptype == PROFILE_SCURVE) ?
                         active_next.accel : active_next.decel; // RULE_10 RULE_11
    velocity_target_next = clamp_velocity(target_vel_next, max_pv_reg); // RULE_04 RULE_05
    limit_low_next = homed && ($signed(position_demand) < $signed(limit_min_reg)); // RULE_01
    limit_high_next = homed && ($signed(position_demand) > $signed(limit_max_reg)); // RULE_01
  end

  // Registers for objects, latch and outputs.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      limit_min_reg <= RESET_LIMIT_MIN;
      limit_max_reg <= RESET_LIMIT_MAX;
      max_pv_reg <= RESET_MAX_PROFILE_VEL;
      max_motor_reg <= RESET_ZERO;
      qs_decel_reg <= RESET_ZERO;
      target_vel_reg <= RESET_ZERO;
      shadow_reg <= '0;
      active_reg <= '0;
      applied_reg <= '0;
      cw_prev_reg <= 1'b0;
      od_rdata_reg <= RESET_ZERO;
      od_ack_reg <= 1'b0;
      od_error_reg <= 1'b0;
      velocity_target_reg <= RESET_ZERO;
      limit_low_reg <= 1'b0;
      limit_high_reg <= 1'b0;
    end else begin
      limit_min_reg <= limit_min_next;
      limit_max_reg <= limit_max_next;
      max_pv_reg <= max_pv_next;
      max_motor_reg <= max_motor_next;
      qs_decel_reg <= qs_decel_next;
      target_vel_reg <= target_vel_next;
      shadow_reg <= shadow_next;
      active_reg <= active_next;
      applied_reg <= applied_next;
      cw_prev_reg <= control_word[CW_NEW_SETPOINT_BIT];
      od_rdata_reg <= od_rdata_next;
      od_ack_reg <= od_ack_next;
      od_error_reg <= od_error_next;
      velocity_target_reg <= velocity_target_next;
      limit_low_reg <= limit_low_next;
      limit_high_reg <= limit_high_next;
    end
  end

  // ----------------------------------------------------------------
  // Quick-stop ramp
  // ----------------------------------------------------------------

  // Ramp applies in the position modes; the source follows the active mode.
  assign ramp_enable = (op_mode == MODE_PROFILE_POSITION) || (op_mode == MODE_HOMING) ||
                       (op_mode == MODE_INTERP_POSITION); // RULE_13
  assign ramp_source = pv_mode ? velocity_target_reg : loop_velocity;

  quick_stop_ramp u_ramp (
    .clk(clk),
    .reset_n(reset_n),
    .stop(quick_stop),
    .enable(ramp_enable),
    .decel(qs_decel_reg),
    .vel_in(ramp_source),
    .vel_reg(velocity_command),
    .stopped_reg(stopped)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_latch_rise;
    op_mode == MODE_PROFILE_POSITION && control_word[CW_NEW_SETPOINT_BIT] && !cw_prev_reg;
  endsequence

  sequence s_no_rise;
    !(op_mode == MODE_PROFILE_POSITION && control_word[CW_NEW_SETPOINT_BIT] && !cw_prev_reg);
  endsequence

  a_limits_unhomed: assert property (@(posedge clk) disable iff (!reset_n) // RULE_01
    !homed |=> (!limit_low_reg && !limit_high_reg))
    else $error("Soft limit flagged before referencing.");
  a_pv_clamp: assert property (@(posedge clk) disable iff (!reset_n) // RULE_04
    (od_write && od_index == IDX_TARGET_VEL && !max_pv_reg[31] && $signed(od_wdata) > $signed(max_pv_reg))
    |=> velocity_target_reg == $past(max_pv_reg))
    else $error("Target velocity not clamped to maximum.");
  a_pv_immediate: assert property (@(posedge clk) disable iff (!reset_n) // RULE_05
    (od_write && od_index == IDX_TARGET_VEL && od_wdata == RESET_ZERO) |=> velocity_target_reg == RESET_ZERO)
    else $error("Target velocity did not pass through at once.");
  a_pp_hold: assert property (@(posedge clk) disable iff (!reset_n) // RULE_06
    s_no_rise |=> (active_reg == $past(active_reg)))
    else $error("Active set changed without a latch.");
  a_latch_copy: assert property (@(posedge clk) disable iff (!reset_n) // RULE_17
    s_latch_rise |=> (active_reg == $past(shadow_reg)) ##0 (applied_reg.cruise_velocity == active_reg.velocity))
    else $error("Latch did not copy the shadow set.");
  a_end_vel_gate: assert property (@(posedge clk) disable iff (!reset_n) // RULE_09
    (active_reg.ptype != PROFILE_TRAPEZOID) |-> applied_reg.end_velocity == RESET_ZERO)
    else $error("End velocity applied outside trapezoidal mode.");
  a_scurve_decel: assert property (@(posedge clk) disable iff (!reset_n) // RULE_10
    (active_reg.ptype == PROFILE_SCURVE) |-> applied_reg.decel == active_reg.accel)
    else $error("S-curve does not decelerate with profile acceleration.");
  a_trap_decel: assert property (@(posedge clk) disable iff (!reset_n) // RULE_11
    (active_reg.ptype != PROFILE_SCURVE) |-> applied_reg.decel == active_reg.decel)
    else $error("Profile deceleration not used for trapezoidal profile.");
  a_type_reject: assert property (@(posedge clk) disable iff (!reset_n) // RULE_16
    (od_write && od_index == IDX_PROFILE_TYPE && od_wdata[15:0] != PROFILE_TRAPEZOID &&
     od_wdata[15:0] != PROFILE_SCURVE && od_wdata[15:0] != PROFILE_VELOCITY)
    |=> (od_error_reg && shadow_reg.ptype == $past(shadow_reg.ptype)))
    else $error("Illegal trajectory type was accepted.");
  a_qs_live_rate: assert property (@(posedge clk) disable iff (!reset_n) // RULE_14
    (od_write && od_index == IDX_QS_DECEL) |=> qs_decel_reg == $past(od_wdata))
    else $error("Quick-stop rate was not taken at once.");
endmodule

/* File: traj_param_pkg.sv */
// Package with object indices, codes, reset values and types for the trajectory parameter latch.
package traj_param_pkg;

  // ----------------------------------------------------------------
  // Object dictionary indices and sub-indices
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_SOFT_LIMIT = 16'h607D;
  localparam logic [15:0] IDX_MAX_PROFILE_VEL = 16'h607F;
  localparam logic [15:0] IDX_MAX_MOTOR_SPEED = 16'h6080;
  localparam logic [15:0] IDX_PROFILE_VEL = 16'h6081;
  localparam logic [15:0] IDX_END_VEL = 16'h6082;
  localparam logic [15:0] IDX_PROFILE_ACCEL = 16'h6083;
  localparam logic [15:0] IDX_PROFILE_DECEL = 16'h6084;
  localparam logic [15:0] IDX_QS_DECEL = 16'h6085;
  localparam logic [15:0] IDX_PROFILE_TYPE = 16'h6086;
  localparam logic [15:0] IDX_TARGET_VEL = 16'h60FF;
  localparam logic [7:0] SUB_PLAIN = 8'h00;
  localparam logic [7:0] SUB_LIMIT_MIN = 8'h01;
  localparam logic [7:0] SUB_LIMIT_MAX = 8'h02;

  // ----------------------------------------------------------------
  // Control word, trajectory type and operating mode codes
  // ----------------------------------------------------------------
  localparam int CW_NEW_SETPOINT_BIT = 4;
  localparam logic [15:0] PROFILE_TRAPEZOID = 16'h0000;
  localparam logic [15:0] PROFILE_SCURVE = 16'h0003;
  localparam logic [15:0] PROFILE_VELOCITY = 16'hFFFF;
  localparam logic [7:0] MODE_PROFILE_POSITION = 8'h01;
  localparam logic [7:0] MODE_PROFILE_VELOCITY = 8'h03;
  localparam logic [7:0] MODE_HOMING = 8'h06;
  localparam logic [7:0] MODE_INTERP_POSITION = 8'h07;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RESET_LIMIT_MIN = 32'h8000_0000;
  localparam logic [31:0] RESET_LIMIT_MAX = 32'h7FFF_FFFF;
  localparam logic [31:0] RESET_MAX_PROFILE_VEL = 32'hFFFF_FFFF;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  localparam logic [15:0] TYPE_PAD = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] velocity;
    logic [31:0] end_velocity;
    logic [31:0] accel;
    logic [31:0] decel;
    logic [15:0] ptype;
  } profile_set_type;

  typedef struct packed {
    logic [31:0] cruise_velocity;
    logic [31:0] end_velocity;
    logic [31:0] accel;
    logic [31:0] decel;
  } applied_type;

  typedef enum logic [2:0] {
    QS_IDLE = 3'h1,
    QS_RAMP = 3'h2,
    QS_HALTED = 3'h4
  } qs_state_type;

endpackage

/* File: quick_stop_ramp.sv */
// Velocity command stage with the quick-stop deceleration ramp.
`timescale 1ns/1ps
module quick_stop_ramp (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic stop,
  input wire logic enable,
  input wire logic [31:0] decel,
  input wire logic [31:0] vel_in,
  // Result
  output logic [31:0] vel_reg,
  output logic stopped_reg
);
  import traj_param_pkg::*;

  qs_state_type state_reg;
  qs_state_type state_next;
  logic [31:0] vel_next;
  logic stopped_next;
  logic [31:0] step_value;
  logic signed [32:0] vel_wide;
  logic signed [32:0] decel_wide;
  logic signed [32:0] mag;
  logic signed [32:0] stepped;

  // One deceleration step toward zero; the rate is read live each cycle.
  always_comb begin
    vel_wide = {vel_reg[31], vel_reg};
    decel_wide = {1'b0, decel};
    mag = vel_reg[31] ? -vel_wide : vel_wide;
    stepped = vel_reg[31] ? (vel_wide + decel_wide) : (vel_wide - decel_wide);
    if ((decel == RESET_ZERO) || (mag <= decel_wide)) begin // RULE_15
      step_value = RESET_ZERO;
    end else begin
      step_value = stepped[31:0]; // RULE_12 RULE_14
    end
  end

  // Next state: follow the input, ramp on a stop, hold zero until release.
  always_comb begin
    state_next = state_reg;
    vel_next = vel_in;
    unique case (state_reg)
      QS_IDLE: begin
        if (stop && enable) begin // RULE_13
          vel_next = step_value;
          state_next = (step_value == RESET_ZERO) ? QS_HALTED : QS_RAMP;
        end
      end
      QS_RAMP: begin
        if (!stop) begin
          state_next = QS_IDLE;
        end else begin
          vel_next = step_value; // RULE_12
          if (step_value == RESET_ZERO) begin
            state_next = QS_HALTED;
          end
        end
      end
      QS_HALTED: begin
        vel_next = RESET_ZERO;
        if (!stop) begin
          state_next = QS_IDLE;
        end
      end
      default: begin
        state_next = QS_IDLE;
      end
    endcase
    stopped_next = (state_next == QS_HALTED);
  end

  // State registers.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= QS_IDLE;
      vel_reg <= RESET_ZERO;
      stopped_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      vel_reg <= vel_next;
      stopped_reg <= stopped_next;
    end
  end

  // Checks on the ramp.
  a_qs_unlimited: assert property (@(posedge clk) disable iff (!reset_n) // RULE_15
    (stop && enable && decel == RESET_ZERO)
    |=> vel_reg == RESET_ZERO)
    else $error("Zero quick-stop rate did not force velocity to zero.");
  a_qs_step_rate: assert property (@(posedge clk) disable iff (!reset_n) // RULE_12
    (stop && enable && state_reg != QS_HALTED && decel != RESET_ZERO && vel_wide > decel_wide)
    |=> vel_reg == $past(vel_reg) - $past(decel))
    else $error("Quick-stop ramp step does not equal the live rate.");
  a_qs_halt_hold: assert property (@(posedge clk) disable iff (!reset_n) // RULE_12
    (state_reg == QS_HALTED && stop) |=> (vel_reg == RESET_ZERO && stopped_reg))
    else $error("Velocity left zero while stop is held.");
endmodule

/* File: od_master.sv */
// Fieldbus master model that issues object dictionary reads and writes.
`timescale 1ns/1ps
module od_master (
  // Clock
  input wire logic clk,
  // Request side
  output logic od_write,
  output logic od_read,
  output logic [15:0] od_index,
  output logic [7:0] od_subindex,
  output logic [31:0] od_wdata,
  // Answer side
  input wire logic [31:0] od_rdata_reg,
  input wire logic od_ack_reg,
  input wire logic od_error_reg
);
  // The bus starts idle with no request pending.
  initial begin
    od_write = 1'b0;
    od_read = 1'b0;
    od_index = 16'h0;
    od_subindex = 8'h0;
    od_wdata = 32'h0;
  end

  // One-cycle request; the answer is taken a cycle later, then the lines are scrambled.
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
                        output logic [31:0] rd, output logic er, ok);
    @(negedge clk);
    od_write = wr;
    od_read = ~wr;
    od_index = idx;
    od_subindex = sub;
    od_wdata = d;
    @(negedge clk);
    ok = od_ack_reg;
    er = od_error_reg;
    rd = od_rdata_reg;
    od_write = 1'b0;
    od_read = 1'b0;
    od_index = ~idx;
    od_subindex = ~sub;
    od_wdata = ~d;
  endtask
endmodule

/* File: test_trajectory_parameter_latch.sv */
// Self-checking testbench for the trajectory parameter latch.
`timescale 1ns/1ps
module test_trajectory_parameter_latch;
  import traj_param_pkg::*;
  typedef struct {logic [15:0] i; logic [7:0] s; logic [31:0] wd, rd; logic we, re;} row_type;
  row_type rows[14];
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic homed, quick_stop, od_write, od_read, od_ack_reg, od_error_reg, stopped, limit_low_reg, limit_high_reg;
  logic [7:0] op_mode, od_subindex;
  logic [15:0] control_word, od_index;
  logic [31:0] position_demand, loop_velocity, od_wdata, od_rdata_reg, velocity_target_reg, velocity_command;
  applied_type applied_reg;
  logic [31:0] ramp[4] = '{32'h46, 32'h28, 32'h0A, 32'h00};
  logic [7:0] stop_modes[2] = '{MODE_HOMING, MODE_INTERP_POSITION};
  int err_total = 0;
  int total_checks = 0;

  // ----------------------------------------------------------------
  // Clock, design and master model
  // ----------------------------------------------------------------
  always #10 clk = ~clk;

  trajectory_parameter_latch dut_u (.clk, .reset_n, .od_write, .od_read, .od_index, .od_subindex, .od_wdata,
    .od_rdata_reg, .od_ack_reg, .od_error_reg, .op_mode, .control_word, .homed, .quick_stop, .position_demand,
    .loop_velocity, .applied_reg, .velocity_target_reg, .velocity_command, .stopped, .limit_low_reg,
    .limit_high_reg);

  od_master master_u (.clk, .od_write, .od_read, .od_index, .od_subindex, .od_wdata, .od_rdata_reg, .od_ack_reg,
    .od_error_reg);

  // ----------------------------------------------------------------
  // Helper tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic flag(input logic seen, input logic exp, input string what);
    check({31'h0, seen}, {31'h0, exp}, what);
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic xfer(input logic wr, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, exp,
                      input logic eexp);
    logic [31:0] rd;
    logic er, ok;
    master_u.access(wr, i, s, d, rd, er, ok);
    flag(ok, 1'b1, "ack");
    flag(er, eexp, "error flag");
    if (!wr && !eexp) check(rd, exp, "read data");
  endtask

  task automatic put(input logic [15:0] i, input logic [31:0] d);
    xfer(1'b1, i, SUB_PLAIN, d, 32'h0, 1'b0);
  endtask

  // A fresh 0 to 1 step of the new-setpoint bit, then time for the set to land.
  task automatic rise_cw;
    control_word[CW_NEW_SETPOINT_BIT] = 1'b0;
    settle(2);
    control_word[CW_NEW_SETPOINT_BIT] = 1'b1;
    settle(2);
  endtask

  task automatic applied_is(input logic [31:0] c, e, a, d);
    check(applied_reg.cruise_velocity, c, "cruise");
    check(applied_reg.end_velocity, e, "end velocity");
    check(applied_reg.accel, a, "accel");
    check(applied_reg.decel, d, "decel");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    op_mode = MODE_PROFILE_POSITION;
    control_word = 16'h0;
    homed = 1'b0;
    quick_stop = 1'b0;
    position_demand = 32'h0;
    loop_velocity = 32'h0;
    rows = '{'{IDX_SOFT_LIMIT, SUB_LIMIT_MIN, 32'hFFFF_F000, 32'hFFFF_F000, 1'b0, 1'b0},
      '{IDX_SOFT_LIMIT, SUB_LIMIT_MAX, 32'h1000, 32'h1000, 1'b0, 1'b0},
      '{IDX_MAX_PROFILE_VEL, SUB_PLAIN, 32'h64, 32'h64, 1'b0, 1'b0},
      '{IDX_MAX_MOTOR_SPEED, SUB_PLAIN, 32'h1234_5678, 32'h1234_5678, 1'b0, 1'b0},
      '{IDX_PROFILE_VEL, SUB_PLAIN, 32'hC8, 32'hC8, 1'b0, 1'b0},
      '{IDX_END_VEL, SUB_PLAIN, 32'h0A, 32'h0A, 1'b0, 1'b0},
      '{IDX_PROFILE_ACCEL, SUB_PLAIN, 32'h28, 32'h28, 1'b0, 1'b0},
      '{IDX_PROFILE_DECEL, SUB_PLAIN, 32'h14, 32'h14, 1'b0, 1'b0},
      '{IDX_QS_DECEL, SUB_PLAIN, 32'h1E, 32'h1E, 1'b0, 1'b0},
      '{IDX_PROFILE_TYPE, SUB_PLAIN, 32'hFFFF, 32'hFFFF, 1'b0, 1'b0},
      '{IDX_TARGET_VEL, SUB_PLAIN, 32'h32, 32'h32, 1'b0, 1'b0},
      '{16'h6040, SUB_PLAIN, 32'h10, 32'h0, 1'b1, 1'b1},
      '{IDX_SOFT_LIMIT, SUB_PLAIN, 32'h2, 32'h0, 1'b1, 1'b1},
      '{IDX_PROFILE_TYPE, SUB_PLAIN, 32'h5, 32'hFFFF, 1'b1, 1'b0}};
    settle(5);
    reset_n = 1'b1;
    // Reset values of the object store and the applied set.
    xfer(1'b0, IDX_SOFT_LIMIT, SUB_LIMIT_MIN, 32'h0, RESET_LIMIT_MIN, 1'b0);
    xfer(1'b0, IDX_SOFT_LIMIT, SUB_LIMIT_MAX, 32'h0, RESET_LIMIT_MAX, 1'b0);
    xfer(1'b0, IDX_MAX_PROFILE_VEL, SUB_PLAIN, 32'h0, RESET_MAX_PROFILE_VEL, 1'b0);
    xfer(1'b0, IDX_PROFILE_TYPE, SUB_PLAIN, 32'h0, {TYPE_PAD, PROFILE_TRAPEZOID}, 1'b0);
    applied_is(RESET_ZERO, RESET_ZERO, RESET_ZERO, RESET_ZERO);
    // Table of writes and read-backs, refused accesses included.
    foreach (rows[k]) begin
      xfer(1'b1, rows[k].i, rows[k].s, rows[k].wd, 32'h0, rows[k].we);
      xfer(1'b0, rows[k].i, rows[k].s, 32'h0, rows[k].rd, rows[k].re);
    end
    applied_is(RESET_ZERO, RESET_ZERO, RESET_ZERO, RESET_ZERO);
    // Target velocity reaches the generator at once, clamped both ways.
    op_mode = MODE_PROFILE_VELOCITY;
    put(IDX_TARGET_VEL, 32'hFA);
    check(velocity_target_reg, 32'h64, "clamp positive");
    put(IDX_TARGET_VEL, 32'hFFFF_FF06);
    check(velocity_target_reg, 32'hFFFF_FF9C, "clamp negative");
    // Buffered set latched on the setpoint step, for the trapezoidal and S-curve types.
    op_mode = MODE_PROFILE_POSITION;
    put(IDX_PROFILE_TYPE, {TYPE_PAD, PROFILE_TRAPEZOID});
    rise_cw;
    applied_is(32'hC8, 32'h0A, 32'h28, 32'h14);
    put(IDX_PROFILE_TYPE, {TYPE_PAD, PROFILE_SCURVE});
    rise_cw;
    applied_is(32'hC8, 32'h00, 32'h28, 32'h28);
    put(IDX_PROFILE_VEL, 32'h300);
    op_mode = MODE_PROFILE_VELOCITY;
    rise_cw;
    applied_is(32'hC8, 32'h00, 32'h28, 32'h28);
    // Software limits act only once referenced; extreme limits switch them off.
    op_mode = MODE_PROFILE_POSITION;
    position_demand = 32'hFFFF_E000;
    settle(2);
    flag(limit_low_reg, 1'b0, "limit before homing");
    homed = 1'b1;
    settle(2);
    flag(limit_low_reg, 1'b1, "low limit");
    position_demand = 32'h2000;
    settle(2);
    flag(limit_high_reg, 1'b1, "high limit");
    xfer(1'b1, IDX_SOFT_LIMIT, SUB_PLAIN, 32'h0, 32'h0, 1'b1);
    xfer(1'b1, IDX_SOFT_LIMIT, SUB_LIMIT_MIN, 32'h8000_0000, 32'h0, 1'b0);
    xfer(1'b1, IDX_SOFT_LIMIT, SUB_LIMIT_MAX, 32'h7FFF_FFFF, 32'h0, 1'b0);
    position_demand = 32'h8000_0000;
    settle(2);
    flag(limit_low_reg, 1'b0, "low limit off");
    position_demand = 32'h7FFF_FFFF;
    settle(2);
    flag(limit_high_reg, 1'b0, "high limit off");
    // Quick-stop ramp at 30 per cycle, then release.
    loop_velocity = 32'h64;
    settle(2);
    check(velocity_command, 32'h64, "follow source");
    quick_stop = 1'b1;
    foreach (ramp[k]) begin
      settle(1);
      check(velocity_command, ramp[k], "ramp step");
    end
    flag(stopped, 1'b1, "stopped");
    quick_stop = 1'b0;
    settle(2);
    check(velocity_command, 32'h64, "released");
    // Zero rate stops at once in the other position modes.
    put(IDX_QS_DECEL, 32'h0);
    foreach (stop_modes[k]) begin
      op_mode = stop_modes[k];
      quick_stop = 1'b1;
      settle(1);
      check(velocity_command, 32'h0, "instant stop");
      quick_stop = 1'b0;
      settle(2);
    end
    op_mode = MODE_PROFILE_VELOCITY;
    quick_stop = 1'b1;
    settle(2);
    check(velocity_command, 32'hFFFF_FF9C, "no ramp in velocity mode");
    conclude;
  end

  // Watchdog against a hung sequence.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    conclude;
  end
endmodule
